/* logic/gpio_cfg_pkg.sv */
/*
 * constants and types for the pin configuration bank of GPIO bits 3.2 to 4.1.
 * assumes a classic Wishbone slave with 32-bit data and a byte address.
 */
package gpio_cfg_pkg;

   // number of pins in the bank
   localparam int NPIN = 8;

   // register indexes; the byte address is four times the index
   localparam logic [7:0] IDX_PIN_3_2_CONFIG = 8'h35;
   localparam logic [7:0] IDX_PIN_3_3_CONFIG = 8'h36;
   localparam logic [7:0] IDX_PIN_3_4_CONFIG = 8'h37;
   localparam logic [7:0] IDX_PIN_3_5_CONFIG = 8'h38;
   localparam logic [7:0] IDX_PIN_3_6_CONFIG = 8'h39;
   localparam logic [7:0] IDX_PIN_3_7_CONFIG = 8'h3a;
   localparam logic [7:0] IDX_PIN_4_0_CONFIG = 8'h3b;
   localparam logic [7:0] IDX_PIN_4_1_CONFIG = 8'h3c;
   localparam logic [7:0] IDX_PIN_DATA = 8'h50;
   localparam logic [7:0] IDX_PIN_LEVEL = 8'h51;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h52;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h53;

   // pin positions inside the bank
   localparam int P_3_2 = 0;
   localparam int P_3_3 = 1;
   localparam int P_3_4 = 2;
   localparam int P_3_5 = 3;
   localparam int P_3_6 = 4;
   localparam int P_3_7 = 5;
   localparam int P_4_0 = 6;
   localparam int P_4_1 = 7;

   // configuration field positions
   localparam int B_DIR_IN = 0;
   localparam int B_INVERT = 1;
   localparam int B_ALT = 2;
   localparam int B_FUNC_LO = 2;
   localparam int B_FUNC_HI = 3;
   localparam int B_OPEN_DRAIN = 7;

   // writable bits: single select and two-bit select registers
   localparam logic [7:0] MASK_CFG_1SEL = 8'h87;
   localparam logic [7:0] MASK_CFG_2SEL = 8'h8f;

   // reset values
   localparam logic [7:0] CFG_RST_STANDBY = 8'h01;
   localparam logic [7:0] CFG_RST_MAIN_FAN = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;

   // pin 4.1 function codes
   localparam logic [1:0] F41_GPIO = 2'b00;
   localparam logic [1:0] F41_DENSITY_1 = 2'b01;
   localparam logic [1:0] F41_EDGE_IRQ = 2'b10;
   localparam logic [1:0] F41_RESERVED = 2'b11;

   // interrupt status bit of the either-edge input
   localparam int S_EDGE_IN2 = 0;

   // bus handshake states
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } bus_state_e;

   typedef logic [7:0] byte_t;

   // whole state of the bank
   typedef struct packed {
      bus_state_e bus;
      logic [31:0] rdat;
      byte_t [NPIN-1:0] cfg;
      byte_t data;
      byte_t pad;
      byte_t status;
      byte_t mask;
      logic irq;
      byte_t pin_out;
      byte_t pin_oe;
      logic smb_data;
      logic irq12;
      logic irq14;
   } bank_state_s;

endpackage : gpio_cfg_pkg

/* logic/gpio_cfg_bank.sv */
/*
 * configuration, pin multiplexing and either-edge interrupt for GPIO bits 3.2 to 4.1,
 * reached as a classic Wishbone slave.
 * assumes pad inputs and alternate function signals are synchronous to clk_i,
 * and that an outside resolver forms each pad level from pin_out_o and pin_oe_o.
 */
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - bit 0 of each pin register makes a pin with no alternate function selected an input when one and an output when zero.
// - bit 1 of each pin register inverts the value between pad and logic when one, except the SMBus drive of pin 3.2.
// - bit 7 of each pin register gives open-drain drive when one and push-pull when zero, except pin 3.2 as SMBus data, always open drain.
// - all pin registers load 0x01 on standby reset, and the fan pin register loads 0x00 on main reset.
// - a one in bit 2 of pin 3.2 connects it to the SMBus data signal.
// - a one in bit 2 of pin 3.3 routes the fan speed output to the pin.
// - a one in bit 2 of pin 3.4 makes it the IRQ12 line.
// - a one in bit 2 of pin 3.5 makes it the IRQ14 line.
// - a one in bit 2 of pin 3.6 drives the active-low keyboard reset out.
// - a one in bit 2 of pin 3.7 drives the active-low gate A20 out.
// - a one in bit 2 of pin 4.0 drives drive density select 0.
// - bits 3 and 2 of pin 4.1 choose GPIO for 00, density select 1 for 01, and 11 is reserved.
// - code 10 in pin 4.1 makes it interrupt input 2, raising an event on either edge.
module gpio_cfg_bank
   import gpio_cfg_pkg::*;
#(
   parameter int AW = 12
) (
   input wire logic clk_i, // system clock
   input wire logic rst_i, // standby power reset, sync high
   input wire logic main_reset_i, // main power reset or hard reset
   input wire logic cyc_i, // wishbone cycle
   input wire logic stb_i, // wishbone strobe
   input wire logic we_i, // wishbone write
   input wire logic [AW-1:0] adr_i, // wishbone byte address
   input wire logic [3:0] sel_i, // wishbone byte select
   input wire logic [31:0] dat_i, // wishbone write data
   output logic [31:0] dat_o, // wishbone read data
   output logic ack_o, // wishbone acknowledge
   output logic irq_o, // level interrupt
   input wire logic [NPIN-1:0] pin_in_i, // pad levels
   output logic [NPIN-1:0] pin_out_o, // pad drive values
   output logic [NPIN-1:0] pin_oe_o, // pad drive enables
   input wire logic smb_drive_low_i, // smbus data pulls low
   output logic smb_data_o, // smbus data seen at pad
   input wire logic fan_speed_i, // fan speed control
   output logic irq12_o, // irq12 line from pad
   output logic irq14_o, // irq14 line from pad
   input wire logic keyboard_reset_out_n_i, // keyboard reset, low active
   input wire logic gate_a20_out_n_i, // gate a20, low active
   input wire logic drive_density_sel_0_i, // density select 0
   input wire logic drive_density_sel_1_i // density select 1
);

   // refuse an address bus too narrow for the index slice adr_i[9:2]
   if (AW < 10) begin : g_aw_check
      $error("gpio_cfg_bank: AW must be at least 10");
   end

   bank_state_s s_q;
   bank_state_s s_d;

   // register index and request decode
   logic [7:0] idx;
   logic req;
   logic wr;
   logic [1:0] f41;
   byte_t lvl;
   byte_t alt_val;
   byte_t alt_drv;
   byte_t alt_out;
   byte_t drv;
   byte_t val;
   logic edge_ev;

   assign idx = adr_i[9:2];
   assign req = cyc_i && stb_i && (s_q.bus == BUS_IDLE);
   assign wr = req && we_i && sel_i[0];
   assign f41 = s_q.cfg[P_4_1][B_FUNC_HI:B_FUNC_LO];

   // pad levels seen by the logic, after polarity
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         lvl[i] = pin_in_i[i] ^ s_q.cfg[i][B_INVERT];
      end
   end

   // alternate function selection per pin
   always_comb begin
      alt_out = '0;
      alt_val = '0;
      alt_drv = '0;
      alt_out[P_3_2] = s_q.cfg[P_3_2][B_ALT];
      alt_drv[P_3_2] = smb_drive_low_i;
      alt_out[P_3_3] = s_q.cfg[P_3_3][B_ALT];
      alt_val[P_3_3] = fan_speed_i;
      alt_drv[P_3_3] = 1'b1;
      alt_out[P_3_4] = s_q.cfg[P_3_4][B_ALT];
      alt_out[P_3_5] = s_q.cfg[P_3_5][B_ALT];
      alt_out[P_3_6] = s_q.cfg[P_3_6][B_ALT];
      alt_val[P_3_6] = keyboard_reset_out_n_i;
      alt_drv[P_3_6] = 1'b1;
      alt_out[P_3_7] = s_q.cfg[P_3_7][B_ALT];
      alt_val[P_3_7] = gate_a20_out_n_i;
      alt_drv[P_3_7] = 1'b1;
      alt_out[P_4_0] = s_q.cfg[P_4_0][B_ALT];
      alt_val[P_4_0] = drive_density_sel_0_i;
      alt_drv[P_4_0] = 1'b1;
      alt_out[P_4_1] = (f41 != F41_GPIO) && (f41 != F41_RESERVED);
      alt_val[P_4_1] = drive_density_sel_1_i;
      alt_drv[P_4_1] = (f41 == F41_DENSITY_1);
   end

   // drive value and enable per pin
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         if (alt_out[i]) begin
            val[i] = alt_val[i] ^ s_q.cfg[i][B_INVERT];
            drv[i] = alt_drv[i];
         end else begin
            val[i] = s_q.data[i] ^ s_q.cfg[i][B_INVERT];
            drv[i] = !s_q.cfg[i][B_DIR_IN];
         end
      end
      // smbus data is open drain and never inverted on drive
      if (alt_out[P_3_2]) begin
         val[P_3_2] = 1'b0;
      end
   end

   // either-edge detector on pin 4.1
   assign edge_ev = (f41 == F41_EDGE_IRQ) && (pin_in_i[P_4_1] != s_q.pad[P_4_1]);

   // next state
   always_comb begin
      s_d = s_q;
      s_d.pad = pin_in_i;
      // pad drivers, open drain only pulls low
      for (int i = 0; i < NPIN; i++) begin
         if (s_q.cfg[i][B_OPEN_DRAIN] || (i == P_3_2 && alt_out[P_3_2])) begin
            s_d.pin_out[i] = 1'b0;
            s_d.pin_oe[i] = drv[i] && !val[i];
         end else begin
            s_d.pin_out[i] = val[i];
            s_d.pin_oe[i] = drv[i];
         end
      end
      // input functions handed to their users
      s_d.smb_data = alt_out[P_3_2] ? lvl[P_3_2] : 1'b1;
      s_d.irq12 = alt_out[P_3_4] && lvl[P_3_4];
      s_d.irq14 = alt_out[P_3_5] && lvl[P_3_5];
      // bus handshake, answer one cycle after the request
      s_d.rdat = '0;
      if (s_q.bus == BUS_ACK) begin
         s_d.bus = BUS_IDLE;
      end else if (req) begin
         s_d.bus = BUS_ACK;
      end
      // register reads, reserved bits as zero
      if (req && !we_i) begin
         case (idx)
            IDX_PIN_DATA: s_d.rdat[7:0] = s_q.data;
            IDX_PIN_LEVEL: s_d.rdat[7:0] = lvl;
            IDX_IRQ_STATUS: s_d.rdat[7:0] = s_q.status;
            IDX_IRQ_MASK: s_d.rdat[7:0] = s_q.mask;
            default: begin
               for (int i = 0; i < NPIN; i++) begin
                  if (idx == IDX_PIN_3_2_CONFIG + 8'(i)) begin
                     s_d.rdat[7:0] = s_q.cfg[i];
                  end
               end
            end
         endcase
      end
      // status clear by writing ones
      if (wr && idx == IDX_IRQ_STATUS) begin
         s_d.status = s_q.status & ~dat_i[7:0];
      end
      // event set wins over a clear in the same cycle
      if (edge_ev) begin
         s_d.status[S_EDGE_IN2] = 1'b1;
      end
      // register writes
      if (wr) begin
         case (idx)
            IDX_PIN_DATA: s_d.data = dat_i[7:0];
            IDX_IRQ_MASK: s_d.mask = dat_i[7:0] & 8'h01;
            IDX_PIN_4_1_CONFIG: s_d.cfg[P_4_1] = dat_i[7:0] & MASK_CFG_2SEL;
            default: begin
               for (int i = 0; i < NPIN - 1; i++) begin
                  if (idx == IDX_PIN_3_2_CONFIG + 8'(i)) begin
                     s_d.cfg[i] = dat_i[7:0] & MASK_CFG_1SEL;
                  end
               end
            end
         endcase
      end
      s_d.irq = |(s_d.status & s_q.mask);
      // main power reset touches only the fan pin
      if (main_reset_i) begin
         s_d.cfg[P_3_3] = CFG_RST_MAIN_FAN;
      end
   end

   // state register with standby reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q.bus <= BUS_IDLE;
         s_q.rdat <= '0;
         for (int i = 0; i < NPIN; i++) begin
            s_q.cfg[i] <= CFG_RST_STANDBY;
         end
         s_q.data <= DATA_RST;
         s_q.pad <= '0;
         s_q.status <= '0;
         s_q.mask <= '0;
         s_q.irq <= 1'b0;
         s_q.pin_out <= '0;
         s_q.pin_oe <= '0;
         s_q.smb_data <= 1'b1;
         s_q.irq12 <= 1'b0;
         s_q.irq14 <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state
   assign dat_o = s_q.rdat;
   assign ack_o = (s_q.bus == BUS_ACK);
   assign irq_o = s_q.irq;
   assign pin_out_o = s_q.pin_out;
   assign pin_oe_o = s_q.pin_oe;
   assign smb_data_o = s_q.smb_data;
   assign irq12_o = s_q.irq12;
   assign irq14_o = s_q.irq14;

endmodule : gpio_cfg_bank

/* verif/gpio_cfg_bank_sva.sv */
/* bus and pad assertions for the pin configuration bank.
   assumes one clock and a synchronous active high reset. */
`timescale 1ns/1ps
module gpio_cfg_bank_sva
   import gpio_cfg_pkg::*;
(
   input wire logic clk_i, // clock
   input wire logic rst_i, // reset
   input wire logic cyc_i, // cycle
   input wire logic stb_i, // strobe
   input wire logic [31:0] dat_o, // read data
   input wire logic ack_o, // acknowledge
   input wire logic irq_o, // interrupt
   input wire logic [NPIN-1:0] pin_out_o, // drive values
   input wire logic [NPIN-1:0] pin_oe_o, // drive enables
   input wire logic smb_data_o, // smbus data
   input wire logic irq12_o, // irq12 line
   input wire logic irq14_o // irq14 line
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // request taken while idle, then a one-cycle answer
   sequence req_s;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence ack_s;
      ack_o ##1 !ack_o;
   endsequence
   ack_take_a: assert property (req_s |=> ack_s) else $error("request not answered by one ack");
   ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i)) else $error("ack without request");
   dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0000_0000) else $error("read data outside ack");
   dat_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000) else $error("upper data not zero");
   rst_pad_a: assert property ($fell(rst_i) |-> pin_oe_o == 8'h00) else $error("pads driven after reset");
   rst_alt_a: assert property ($fell(rst_i) |-> smb_data_o && !irq12_o && !irq14_o)
      else $error("alternate outputs wrong after reset");
   rst_irq_a: assert property ($fell(rst_i) |-> !irq_o && !ack_o) else $error("irq or ack after reset");
   irq12_in_a: assert property (irq12_o |-> !pin_oe_o[P_3_4]) else $error("irq12 pin driven");
endmodule : gpio_cfg_bank_sva

bind gpio_cfg_bank gpio_cfg_bank_sva gpio_cfg_bank_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
   .smb_data_o(smb_data_o), .irq12_o(irq12_o), .irq14_o(irq14_o));

/* verif/pad_board.sv */
/* board side of the pads: resolves each pad from the bank and a board driver.
   assumes released pads are pulled high on the board. */
`timescale 1ns/1ps
module pad_board
   import gpio_cfg_pkg::*;
(
   input wire logic [NPIN-1:0] pin_out_i, // bank drive values
   input wire logic [NPIN-1:0] pin_oe_i, // bank drive enables
   input wire logic [NPIN-1:0] ext_val_i, // board drive values
   input wire logic [NPIN-1:0] ext_en_i, // board drive enables
   output logic [NPIN-1:0] pad_o // pad levels
);
   // bank first, then board, else pull-up
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         pad_o[i] = pin_oe_i[i] ? pin_out_i[i] : (ext_en_i[i] ? ext_val_i[i] : 1'h1);
      end
   end
endmodule : pad_board

/* verif/gpio_cfg_bank_tb_top.sv */
/* register and pad tests of the pin configuration bank.
   assumes the pad_board model and the bound checker. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module gpio_cfg_bank_tb_top;
   import gpio_cfg_pkg::*;
   logic clk_i, rst_i, main_reset_i, cyc_i, stb_i, we_i, ack_o, irq_o, smb_low, smb_data_o, fan, irq12_o, irq14_o;
   logic kbd_n, a20_n, den0, den1;
   logic [11:0] adr_i;
   logic [31:0] dat_i, dat_o;
   logic [7:0] pin_in_i, pin_out_o, pin_oe_o, ext_val, ext_en;
   int error_cnt = 0;
   int comparisons = 0;
   gpio_cfg_bank gpio_cfg_bank_inst (.clk_i(clk_i), .rst_i(rst_i), .main_reset_i(main_reset_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .irq_o(irq_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .smb_drive_low_i(smb_low),
      .smb_data_o(smb_data_o), .fan_speed_i(fan), .irq12_o(irq12_o), .irq14_o(irq14_o),
      .keyboard_reset_out_n_i(kbd_n), .gate_a20_out_n_i(a20_n), .drive_density_sel_0_i(den0),
      .drive_density_sel_1_i(den1));
   pad_board pad_board_inst (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .ext_val_i(ext_val), .ext_en_i(ext_en),
      .pad_o(pin_in_i));
   // verdict and end of run
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop
   // one classic wishbone cycle, bounded wait for ack
   task automatic wb(input logic w, input byte_t i, input byte_t wd, output byte_t rd);
      int n;
      n = 0;
      cyc_i <= 1'h1;
      stb_i <= 1'h1;
      we_i <= w;
      adr_i <= {2'h0, i, 2'h0};
      dat_i <= {24'h00_0000, wd};
      // look at ack in mid-cycle, where it has settled
      do begin
         @(negedge clk_i);
         n++;
      end while (ack_o !== 1'h1 && n < 20);
      rd = dat_o[7:0];
      // the edge at which ack is sampled high ends the request
      @(posedge clk_i);
      cyc_i <= 1'h0;
      stb_i <= 1'h0;
      @(posedge clk_i);
      if (n >= 20) begin
         error_cnt++;
         report_and_stop();
      end
   endtask : wb
   task automatic wr(input byte_t i, input byte_t d);
      byte_t r;
      wb(1'h1, i, d, r);
   endtask : wr
   task automatic rchk(input byte_t i, input byte_t e);
      byte_t r;
      wb(1'h0, i, 8'h00, r);
      `CHK($sformatf("reg %h", i), e, r)
   endtask : rchk
   task automatic cfg_all(input byte_t v);
      for (int i = 0; i < NPIN; i++) wr(byte_t'(IDX_PIN_3_2_CONFIG + i), v);
      repeat (3) @(posedge clk_i);
   endtask : cfg_all
   initial begin
      clk_i = 1'h0;
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      {rst_i, main_reset_i, cyc_i, stb_i, we_i, smb_low, fan, kbd_n, a20_n, den0, den1} = 11'h400;
      {adr_i, dat_i, ext_val, ext_en} = 60'h0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'h0;
      for (int i = 0; i < NPIN; i++) rchk(byte_t'(IDX_PIN_3_2_CONFIG + i), CFG_RST_STANDBY);
      rchk(8'h00, 8'h00);
      for (int i = 0; i < NPIN; i++) wr(byte_t'(IDX_PIN_3_2_CONFIG + i), 8'hff);
      for (int i = 0; i < NPIN; i++) rchk(byte_t'(IDX_PIN_3_2_CONFIG + i), i == 7 ? 8'h8f : 8'h87);
      main_reset_i <= 1'h1;
      @(posedge clk_i);
      main_reset_i <= 1'h0;
      rchk(IDX_PIN_3_3_CONFIG, CFG_RST_MAIN_FAN);
      rchk(IDX_PIN_3_2_CONFIG, 8'h87);
      // standby reset again in mid-run
      rst_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      rchk(IDX_PIN_3_3_CONFIG, CFG_RST_STANDBY);
      rchk(IDX_PIN_4_1_CONFIG, CFG_RST_STANDBY);
      $display("test registers done");
      wr(IDX_PIN_DATA, 8'h5a);
      cfg_all(8'h00);
      `CHK("oe", 8'hff, pin_oe_o)
      `CHK("out", 8'h5a, pin_out_o)
      cfg_all(8'h02);
      `CHK("inverted", 8'ha5, pin_out_o)
      cfg_all(8'h80);
      `CHK("drain oe", 8'ha5, pin_oe_o)
      `CHK("drain out", 8'h00, pin_out_o)
      ext_en <= 8'hff;
      ext_val <= 8'h3c;
      cfg_all(8'h01);
      `CHK("in oe", 8'h00, pin_oe_o)
      rchk(IDX_PIN_LEVEL, 8'h3c);
      cfg_all(8'h03);
      rchk(IDX_PIN_LEVEL, 8'hc3);
      $display("test gpio done");
      ext_en <= 8'h0c;
      cfg_all(8'h04);
      for (int v = 0; v < 2; v++) begin
         {fan, kbd_n, a20_n, den0, den1, smb_low} <= {{5{v[0]}}, !v[0]};
         ext_val <= {8{v[0]}};
         repeat (3) @(posedge clk_i);
         `CHK("alt oe", v ? 8'hf2 : 8'hf3, pin_oe_o)
         `CHK("alt out", v ? 8'hf2 : 8'h00, pin_out_o)
         `CHK("smb", v[0], smb_data_o)
         `CHK("irq lines", {2{v[0]}}, {irq12_o, irq14_o})
      end
      $display("test alternates done");
      cfg_all(8'h01);
      wr(IDX_PIN_4_1_CONFIG, 8'h09);
      wr(IDX_IRQ_MASK, 8'h01);
      ext_en <= 8'h80;
      ext_val <= 8'h00;
      repeat (3) @(posedge clk_i);
      wr(IDX_IRQ_STATUS, 8'h01);
      // rising then falling edge
      for (int v = 1; v >= 0; v--) begin
         ext_val <= {v[0], 7'h00};
         repeat (3) @(posedge clk_i);
         `CHK("irq", 1'h1, irq_o)
         rchk(IDX_IRQ_STATUS, 8'h01);
         wr(IDX_IRQ_STATUS, 8'h01);
         `CHK("irq cleared", 1'h0, irq_o)
      end
      wr(IDX_IRQ_MASK, 8'h00);
      ext_val <= 8'h80;
      repeat (3) @(posedge clk_i);
      `CHK("masked", 1'h0, irq_o)
      rchk(IDX_IRQ_STATUS, 8'h01);
      wr(IDX_IRQ_STATUS, 8'h01);
      wr(IDX_PIN_4_1_CONFIG, 8'h0d);
      ext_val <= 8'h00;
      repeat (3) @(posedge clk_i);
      rchk(IDX_IRQ_STATUS, 8'h00);
      $display("test edge interrupt done");
      report_and_stop();
   end
endmodule : gpio_cfg_bank_tb_top
